// File: src/osdcar_top.sv
// osdcar_top: display cell store, attribute decode and dot colour output
// assumes decoded host writes, external glyph store, external timing
//
// Operation
// - dot rate is flyback times setting times 12
// - dot rate 6 to 150 MHz by range
// - no flyback, run internal 2.5 MHz oscillator
// - 15 rows by 30 columns, code and attribute
// - row control byte at code column 30
// - wide rows show even columns only
// - code ranges standard, user, multi-colour glyphs
// - box bit picks background or shape
// - bit1 tall, bit0 wide, per row
// - background code zero is transparent
// - shape start codes, raised or depressed
// - middle and end codes; start fixes kind
// - blink bit toggles every 32 frames
// - attribute bits 2..0 are foreground colour
// - glyphs are 12 dots by 18 lines
// - multi-colour glyph planes drive rgb directly
// - multi-colour zero dot shows background
// - code msb from column byte bit5
// - line has setting times 12 dots, 360 active
`timescale 1ns/1ps
`default_nettype none
module osdcar_top #(
    parameter int FLY_LOSS_CYC = osdcar_pkg::FLY_LOSS_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic line_flyback_in,
    input wire logic frame_flyback_in,
    input wire logic osc_range_hi,
    input wire logic osc_range_lo,
    input wire logic [7:0] line_dots_div12,
    input wire logic wr_valid,
    input wire osdcar_pkg::osdcar_wr_t wr,
    input wire logic disp_on,
    input wire logic [4:0] disp_row,
    input wire logic [5:0] disp_line,
    output logic [8:0] glyph_rom_code,
    output logic [4:0] glyph_rom_line,
    input wire osdcar_pkg::osdcar_dots_t glyph_rom_dots,
    output logic dot_clock_synth,
    output logic dot_locked,
    output logic dot_band_ok,
    output osdcar_pkg::osdcar_pix_t pix
);
    typedef struct packed {
        logic [1:0] fly_sy;
        logic fly_d;
        logic [1:0] frm_sy;
        logic frm_d;
        logic [11:0] dotx;
        logic [4:0] frm_cnt;
        logic blink_ph;
        logic box_open;
        logic box_rsd;
        osdcar_pkg::osdcar_pix_t pix;
    } osdcar_st_t;

    osdcar_st_t s_r, s_nxt;

    logic [8:0] code_mem [0:osdcar_pkg::ROWS-1][0:osdcar_pkg::COLS-1];
    logic [7:0] attr_mem [0:osdcar_pkg::ROWS-1][0:osdcar_pkg::COLS-1];
    logic [7:0] ctrl_mem [0:osdcar_pkg::ROWS-1];

    logic fly_edge;
    logic frm_edge;
    logic dot_tick;
    logic [11:0] line_len;
    logic [4:0] wcol;
    logic wr_row_ok;

    logic active;
    logic [3:0] rix;
    logic [4:0] col;
    logic [3:0] sub;
    logic [7:0] ctrl;
    logic [7:0] attr;
    logic [8:0] code;
    logic row_tall;
    logic row_wide;
    logic box_mode;
    logic [2:0] shape;
    logic [2:0] backdrop;
    logic multi;
    logic [2:0] mdot;
    logic mono;
    logic hidden;
    logic cell_last_dot;
    logic [4:0] gline;

    function automatic logic [4:0] cell_col(input logic [11:0] x, input logic wide);
        logic [11:0] c;
        c = wide ? (x / 12'd24) * 12'd2 : x / 12'd12;
        cell_col = c[4:0];
    endfunction

    function automatic logic [3:0] cell_sub(input logic [11:0] x, input logic wide);
        logic [11:0] c;
        c = wide ? (x % 12'd24) >> 1 : x % 12'd12;
        cell_sub = c[3:0];
    endfunction

    function automatic logic dot_at(input logic [11:0] plane, input logic [3:0] s);
        logic [3:0] i;
        i = 4'(osdcar_pkg::DOTS_PER_GLYPH - 1) - s;
        dot_at = plane[i];
    endfunction

    assign fly_edge = s_r.fly_sy[1] & ~s_r.fly_d;
    assign frm_edge = s_r.frm_sy[1] & ~s_r.frm_d;

    osdcar_dotsyn #(
        .LOSS_CYC(FLY_LOSS_CYC)
    ) u_dotsyn (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .fly_edge(fly_edge),
        .line_dots_div12(line_dots_div12),
        .osc_range({osc_range_hi, osc_range_lo}),
        .dot_tick(dot_tick),
        .locked(dot_locked),
        .band_ok(dot_band_ok)
    );

    // host write port
    assign wcol = wr.col_byte[4:0];
    assign wr_row_ok = wr.row <= osdcar_pkg::ROW_LAST;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            for (int r = 0; r < osdcar_pkg::ROWS; r++) begin
                ctrl_mem[r] <= osdcar_pkg::CTRL_RESET;
            end
        end else if (wr_valid && wr_row_ok) begin
            if (!wr.attr_plane && wcol == osdcar_pkg::COL_ROWCTRL) begin
                ctrl_mem[wr.row[3:0]] <= wr.data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_valid && wr_row_ok && wcol <= osdcar_pkg::COL_LAST) begin
            if (wr.attr_plane) begin
                attr_mem[wr.row[3:0]][wcol] <= wr.data;
            end else begin
                code_mem[wr.row[3:0]][wcol] <= {wr.col_byte[osdcar_pkg::COLBYTE_MSB], wr.data};
            end
        end
    end

    // cell lookup
    // active part of the line
    assign line_len = 12'({4'h0, line_dots_div12} * 12'd12);
    assign active = disp_on && disp_row <= osdcar_pkg::ROW_LAST
        && s_r.dotx < 12'(osdcar_pkg::ACTIVE_DOTS);
    assign rix = disp_row[3:0];
    assign ctrl = ctrl_mem[rix];
    assign row_tall = ctrl[osdcar_pkg::CTRL_TALL];
    assign row_wide = ctrl[osdcar_pkg::CTRL_WIDE];
    assign box_mode = ctrl[osdcar_pkg::CTRL_BOX];
    // wide rows map to even cells
    assign col = cell_col(s_r.dotx, row_wide);
    assign sub = cell_sub(s_r.dotx, row_wide);
    assign attr = attr_mem[rix][col];
    assign code = code_mem[rix][col];

    always_comb begin
        gline = row_tall ? disp_line[5:1] : disp_line[4:0];
        if (gline > 5'(osdcar_pkg::GLYPH_LINES - 1)) begin
            gline = 5'(osdcar_pkg::GLYPH_LINES - 1);
        end
    end

    assign glyph_rom_code = code;
    assign glyph_rom_line = gline;

    assign shape = box_mode ? attr[osdcar_pkg::ATTR_SHAPE_HI:osdcar_pkg::ATTR_SHAPE_LO] : 3'h0;
    assign backdrop = box_mode ? 3'h0 : attr[osdcar_pkg::ATTR_SHAPE_HI:osdcar_pkg::ATTR_SHAPE_LO];

    assign multi = code >= osdcar_pkg::CODE_MULTI_FIRST;
    assign mdot = {dot_at(glyph_rom_dots.r, sub),
                   dot_at(glyph_rom_dots.g, sub),
                   dot_at(glyph_rom_dots.b, sub)};
    assign mono = dot_at(glyph_rom_dots.r, sub);
    assign hidden = attr[osdcar_pkg::ATTR_BLINK] & s_r.blink_ph;
    assign cell_last_dot = dot_tick
        && sub == 4'(osdcar_pkg::DOTS_PER_GLYPH - 1)
        && (!row_wide || s_r.dotx % 12'd24 == 12'd23);

    always_comb begin
        s_nxt = s_r;
        s_nxt.fly_sy = {s_r.fly_sy[0], line_flyback_in};
        s_nxt.fly_d = s_r.fly_sy[1];
        s_nxt.frm_sy = {s_r.frm_sy[0], frame_flyback_in};
        s_nxt.frm_d = s_r.frm_sy[1];

        if (fly_edge) begin
            s_nxt.dotx = '0;
            s_nxt.box_open = 1'b0;
        end else if (dot_tick && s_r.dotx < line_len - 12'd1) begin
            s_nxt.dotx = s_r.dotx + 12'd1;
        end

        if (frm_edge) begin
            s_nxt.frm_cnt = s_r.frm_cnt + 5'd1;
            if (s_r.frm_cnt == osdcar_pkg::FRAME_WRAP) begin
                s_nxt.blink_ph = ~s_r.blink_ph;
            end
        end

        s_nxt.pix = '0;
        if (active) begin
            s_nxt.pix.user_glyph = code >= osdcar_pkg::CODE_USER_FIRST
                && code <= osdcar_pkg::CODE_USER_LAST;
            s_nxt.pix.bg_on = backdrop != 3'h0;
            if (multi) begin
                s_nxt.pix.glyph_on = !hidden && mdot != 3'h0;
                s_nxt.pix.rgb = mdot;
            end else begin
                s_nxt.pix.glyph_on = !hidden && mono;
                s_nxt.pix.rgb = attr[2:0];
            end
            if (!s_nxt.pix.glyph_on) begin
                s_nxt.pix.rgb = backdrop;
            end

            if (shape[2]) begin
                s_nxt.pix.box_on = 1'b1;
                s_nxt.pix.box_raised = shape[1];
                s_nxt.pix.box_left = 1'b1;
                s_nxt.pix.box_right = shape[0];
            end else if (shape == osdcar_pkg::SHAPE_MID && s_r.box_open) begin
                s_nxt.pix.box_on = 1'b1;
                s_nxt.pix.box_raised = s_r.box_rsd;
            end else if (shape == osdcar_pkg::SHAPE_END && s_r.box_open) begin
                s_nxt.pix.box_on = 1'b1;
                s_nxt.pix.box_raised = s_r.box_rsd;
                s_nxt.pix.box_right = 1'b1;
            end
            s_nxt.pix.on = s_nxt.pix.glyph_on | s_nxt.pix.bg_on | s_nxt.pix.box_on;

            if (cell_last_dot && !fly_edge) begin
                s_nxt.box_open = s_nxt.pix.box_on & ~s_nxt.pix.box_right;
                s_nxt.box_rsd = s_nxt.pix.box_raised;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dot_clock_synth = dot_tick;
    assign pix = s_r.pix;
endmodule
`default_nettype wire

// File: src/osdcar_pkg.sv
// osdcar_pkg: constants and carrier types of the osd cell front end
// assumes a 200 MHz sys_clk shared by every user of these types
package osdcar_pkg;

    localparam int SYS_KHZ = 200000;
    localparam int OSC_FALLBACK_KHZ = 2500;
    localparam int OSC_DIV = SYS_KHZ / OSC_FALLBACK_KHZ;
    localparam int FLY_LOSS_US = 100;
    localparam int FLY_LOSS_CYC = FLY_LOSS_US * (SYS_KHZ / 1000);

    localparam int DOTS_PER_GLYPH = 12;
    localparam int GLYPH_LINES = 18;
    localparam int ACTIVE_DOTS = 360;
    localparam int ROWS = 15;
    localparam int COLS = 30;
    localparam logic [4:0] ROW_LAST = 5'h0e;
    localparam logic [4:0] COL_LAST = 5'h1d;
    localparam logic [4:0] COL_ROWCTRL = 5'h1e;

    localparam logic [8:0] CODE_USER_FIRST = 9'h168;
    localparam logic [8:0] CODE_USER_LAST = 9'h16f;
    localparam logic [8:0] CODE_MULTI_FIRST = 9'h170;

    localparam int CTRL_BOX = 4;
    localparam int CTRL_TALL = 1;
    localparam int CTRL_WIDE = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int COLBYTE_MSB = 5;
    localparam int ATTR_BLINK = 3;
    localparam int ATTR_SHAPE_HI = 6;
    localparam int ATTR_SHAPE_LO = 4;
    localparam logic [2:0] SHAPE_MID = 3'h2;
    localparam logic [2:0] SHAPE_END = 3'h1;
    localparam logic [4:0] FRAME_WRAP = 5'h1f;

    localparam int BAND_LO_MHZ_0 = 6;
    localparam int BAND_HI_MHZ_0 = 25;
    localparam int BAND_HI_MHZ_1 = 50;
    localparam int BAND_HI_MHZ_2 = 100;
    localparam int BAND_HI_MHZ_3 = 150;
    localparam int SYS_MHZ = SYS_KHZ / 1000;

    typedef struct packed {
        logic attr_plane;
        logic [4:0] row;
        logic [7:0] col_byte;
        logic [7:0] data;
    } osdcar_wr_t;

    typedef struct packed {
        logic [11:0] r;
        logic [11:0] g;
        logic [11:0] b;
    } osdcar_dots_t;

    typedef struct packed {
        logic on;
        logic [2:0] rgb;
        logic glyph_on;
        logic bg_on;
        logic box_on;
        logic box_raised;
        logic box_left;
        logic box_right;
        logic user_glyph;
    } osdcar_pix_t;

endpackage

// File: src/osdcar_dotsyn.sv
// osdcar_dotsyn: dot-rate tick locked to the line flyback, with fallback
// assumes fly_edge is an already synchronised one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module osdcar_dotsyn #(
    parameter int LOSS_CYC = osdcar_pkg::FLY_LOSS_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic fly_edge,
    input wire logic [7:0] line_dots_div12,
    input wire logic [1:0] osc_range,
    output logic dot_tick,
    output logic locked,
    output logic band_ok
);
    typedef struct packed {
        logic [19:0] per_cnt;
        logic [19:0] period;
        logic [19:0] acc;
        logic [6:0] osc_cnt;
        logic lock;
        logic tick;
    } osdcar_syn_t;

    osdcar_syn_t s_r, s_nxt;
    logic [19:0] n_dots;
    logic [19:0] sum;
    logic [31:0] f_num;
    logic [31:0] lo_lim;
    logic [31:0] hi_lim;

    assign n_dots = 20'({line_dots_div12, 2'b00}) * 20'd3;
    assign sum = s_r.acc + n_dots;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.per_cnt = s_r.per_cnt + 20'd1;
        if (s_r.per_cnt >= 20'(LOSS_CYC)) begin
            s_nxt.lock = 1'b0;
            s_nxt.per_cnt = s_r.per_cnt;
        end
        if (fly_edge) begin
            s_nxt.period = s_r.per_cnt;
            s_nxt.per_cnt = 20'd1;
            s_nxt.lock = s_r.per_cnt < 20'(LOSS_CYC);
            s_nxt.acc = '0;
        end else if (s_r.lock) begin
            if (sum >= s_r.period) begin
                s_nxt.acc = sum - s_r.period;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.acc = sum;
            end
        end else begin
            s_nxt.osc_cnt = s_r.osc_cnt + 7'd1;
            if (s_r.osc_cnt == 7'(osdcar_pkg::OSC_DIV - 1)) begin
                s_nxt.osc_cnt = '0;
                s_nxt.tick = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        f_num = 32'(n_dots) * 32'(osdcar_pkg::SYS_MHZ);
        unique case (osc_range)
            2'h0: lo_lim = 32'(osdcar_pkg::BAND_LO_MHZ_0);
            2'h1: lo_lim = 32'(osdcar_pkg::BAND_HI_MHZ_0);
            2'h2: lo_lim = 32'(osdcar_pkg::BAND_HI_MHZ_1);
            2'h3: lo_lim = 32'(osdcar_pkg::BAND_HI_MHZ_2);
        endcase
        unique case (osc_range)
            2'h0: hi_lim = 32'(osdcar_pkg::BAND_HI_MHZ_0);
            2'h1: hi_lim = 32'(osdcar_pkg::BAND_HI_MHZ_1);
            2'h2: hi_lim = 32'(osdcar_pkg::BAND_HI_MHZ_2);
            2'h3: hi_lim = 32'(osdcar_pkg::BAND_HI_MHZ_3);
        endcase
        lo_lim = lo_lim * 32'(s_r.period);
        hi_lim = hi_lim * 32'(s_r.period);
    end

    assign dot_tick = s_r.tick;
    assign locked = s_r.lock;
    assign band_ok = s_r.lock && (f_num >= lo_lim) && (f_num <= hi_lim);
endmodule
`default_nettype wire

// File: testbench/osdcar_host_model.sv
// host writer and glyph store model for osdcar_top
// assumes the bench calls put and idle from its main sequence
`timescale 1ns/1ps
`default_nettype none
module osdcar_host_model (
    input wire logic sys_clk,
    output logic wr_valid,
    output osdcar_pkg::osdcar_wr_t wr,
    input wire logic [8:0] glyph_rom_code,
    output osdcar_pkg::osdcar_dots_t glyph_rom_dots
);
    initial begin
        wr_valid = 1'b0;
        wr = '0;
    end
    always_comb begin
        glyph_rom_dots.r = (glyph_rom_code >= osdcar_pkg::CODE_MULTI_FIRST) ? 12'h000 : 12'hf00;
        glyph_rom_dots.g = 12'hf0f;
        glyph_rom_dots.b = 12'h0ff;
    end
    task automatic put(input logic pl, input logic [4:0] row, input logic [7:0] cb,
                       input logic [7:0] d);
        @(posedge sys_clk);
        wr_valid <= 1'b1;
        wr <= '{pl, row, cb, d};
    endtask
    // released bus shows a changed pattern
    task automatic idle();
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        wr <= ~wr;
    endtask
endmodule
`default_nettype wire

// File: testbench/osdcar_top_checker.sv
// port assertions for osdcar_top
// assumes bind onto osdcar_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module osdcar_top_checker #(
    parameter int FLY_LOSS_CYC = osdcar_pkg::FLY_LOSS_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic line_flyback_in,
    input wire logic disp_on,
    input wire logic [4:0] disp_row,
    input wire logic [5:0] disp_line,
    input wire logic [8:0] glyph_rom_code,
    input wire logic [4:0] glyph_rom_line,
    input wire logic dot_clock_synth,
    input wire logic dot_locked,
    input wire osdcar_pkg::osdcar_pix_t pix
);
    logic [15:0] quiet_r;
    logic [7:0] gap_r;
    logic [1:0] unl_r;
    logic calm;
    assign calm = quiet_r > 16'(FLY_LOSS_CYC + 8);
    always_ff @(posedge sys_clk) begin
        quiet_r <= (!rstn || line_flyback_in) ? 16'h0 : quiet_r + {15'h0, quiet_r != 16'hffff};
        gap_r <= (!rstn || dot_clock_synth) ? 8'h0 : gap_r + {7'h0, gap_r != 8'hff};
        if (!rstn || (dot_clock_synth && dot_locked)) begin
            unl_r <= 2'h0;
        end else if (dot_clock_synth && unl_r != 2'h2) begin
            unl_r <= unl_r + 2'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_unlock; calm |-> !dot_locked; endproperty
    a_unlock: assert property (p_unlock) else $error("locked without flyback");
    property p_osc; calm && dot_clock_synth && unl_r == 2'h2 |-> gap_r == 8'd79; endproperty
    a_osc: assert property (p_osc) else $error("fallback tick spacing wrong");
    property p_dark; !disp_on || disp_row > osdcar_pkg::ROW_LAST |=> pix == '0; endproperty
    a_dark: assert property (p_dark) else $error("pixel outside display");
    property p_line;
        disp_on |-> glyph_rom_line <= 5'd17 && (glyph_rom_line == disp_line[4:0]
            || glyph_rom_line == disp_line[5:1] || glyph_rom_line == 5'd17);
    endproperty
    a_line: assert property (p_line) else $error("glyph line out of range");
    property p_user;
        pix.user_glyph |-> $past(glyph_rom_code) >= osdcar_pkg::CODE_USER_FIRST
            && $past(glyph_rom_code) <= osdcar_pkg::CODE_USER_LAST;
    endproperty
    a_user: assert property (p_user) else $error("user flag on wrong code");
    property p_nobg; pix.box_on |-> !pix.bg_on; endproperty
    a_nobg: assert property (p_nobg) else $error("backdrop in box row");
    property p_multi;
        pix.glyph_on && $past(glyph_rom_code) >= osdcar_pkg::CODE_MULTI_FIRST |-> pix.rgb != 3'h0;
    endproperty
    a_multi: assert property (p_multi) else $error("black multi colour dot");
    property p_edge; pix.box_left || pix.box_right || pix.box_raised |-> pix.box_on; endproperty
    a_edge: assert property (p_edge) else $error("box flag without box");
    c_user: cover property (pix.user_glyph);
    c_box: cover property (pix.box_raised);
    c_osc: cover property (calm && dot_clock_synth);
endmodule
bind osdcar_top osdcar_top_checker #(.FLY_LOSS_CYC(FLY_LOSS_CYC)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .line_flyback_in(line_flyback_in), .disp_on(disp_on),
    .disp_row(disp_row), .disp_line(disp_line), .glyph_rom_code(glyph_rom_code),
    .glyph_rom_line(glyph_rom_line), .dot_clock_synth(dot_clock_synth),
    .dot_locked(dot_locked), .pix(pix)
);
`default_nettype wire

// File: testbench/osdcar_tb_top.sv
// self-checking bench for osdcar_top
// assumes host model and bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin n_fail++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module osdcar_tb_top;
    localparam int FLY = 1500;
    logic sys_clk, rstn, line_flyback_in, frame_flyback_in, osc_range_hi, osc_range_lo;
    logic wr_valid, disp_on, dot_clock_synth, dot_locked, dot_band_ok, mon, multi, fly_on;
    logic [7:0] line_dots_div12;
    logic [4:0] disp_row, glyph_rom_line;
    logic [5:0] disp_line;
    logic [8:0] glyph_rom_code, prev_code, exp_code;
    logic [2:0] fg_e, fg_o, bg_o, s;
    logic [9:0] fly_cnt;
    osdcar_pkg::osdcar_wr_t wr;
    osdcar_pkg::osdcar_dots_t glyph_rom_dots;
    osdcar_pkg::osdcar_pix_t pix;
    int n_fail, n_compared, n_e, n_o, n_bg, n_box, n_rs, n_rt, n_tick, seed, v;
    osdcar_top #(.FLY_LOSS_CYC(FLY)) DUT (.sys_clk(sys_clk), .rstn(rstn),
        .line_flyback_in(line_flyback_in), .frame_flyback_in(frame_flyback_in),
        .osc_range_hi(osc_range_hi), .osc_range_lo(osc_range_lo),
        .line_dots_div12(line_dots_div12), .wr_valid(wr_valid), .wr(wr), .disp_on(disp_on),
        .disp_row(disp_row), .disp_line(disp_line), .glyph_rom_code(glyph_rom_code),
        .glyph_rom_line(glyph_rom_line), .glyph_rom_dots(glyph_rom_dots),
        .dot_clock_synth(dot_clock_synth), .dot_locked(dot_locked),
        .dot_band_ok(dot_band_ok), .pix(pix));
    osdcar_host_model host (.sys_clk(sys_clk), .wr_valid(wr_valid), .wr(wr),
        .glyph_rom_code(glyph_rom_code), .glyph_rom_dots(glyph_rom_dots));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    function automatic logic band_exp(input int b, input int d);
        int lim[5];
        int f;
        lim = '{osdcar_pkg::BAND_LO_MHZ_0, osdcar_pkg::BAND_HI_MHZ_0,
            osdcar_pkg::BAND_HI_MHZ_1, osdcar_pkg::BAND_HI_MHZ_2, osdcar_pkg::BAND_HI_MHZ_3};
        f = (osdcar_pkg::SYS_KHZ / 1000) * 12 * d;
        return f >= lim[b] * 1000 && f <= lim[b + 1] * 1000;
    endfunction
    function automatic logic user_exp(input logic [8:0] c);
        return c >= osdcar_pkg::CODE_USER_FIRST && c <= osdcar_pkg::CODE_USER_LAST;
    endfunction
    // flyback source, tick count and pixel monitor
    always @(posedge sys_clk) begin
        fly_cnt <= (fly_cnt == 10'd999) ? 10'd0 : fly_cnt + 10'd1;
        line_flyback_in <= fly_on && (fly_cnt < 10'd8);
        prev_code <= glyph_rom_code;
        if (dot_clock_synth === 1'b1) n_tick++;
        if (mon) begin
            if (pix.glyph_on === 1'b1) begin
                `CHK("glyph_code", exp_code, prev_code)
                `CHK("user_flag", user_exp(exp_code), pix.user_glyph)
                `CHK("pix_on", 1'b1, pix.on)
                if (multi) begin
                    n_e++;
                    `CHK("multi_red", 1'b0, pix.rgb[2])
                end else if (pix.rgb === fg_o) begin
                    n_o++;
                end else begin
                    n_e++;
                    `CHK("fg", fg_e, pix.rgb)
                end
            end
            if (pix.bg_on === 1'b1 && pix.glyph_on !== 1'b1) begin
                n_bg++;
                `CHK("backdrop", bg_o, pix.rgb)
            end
            if (pix.box_on === 1'b1) n_box++;
            if (pix.box_on === 1'b1 && pix.box_raised === 1'b1) n_rs++;
            if (pix.box_on === 1'b1 && pix.box_right === 1'b1) n_rt++;
        end
    end
    task automatic fill(input logic [4:0] row, input logic [8:0] code, input logic [7:0] ae,
                        input logic [7:0] ao);
        for (int c = 0; c < 30; c++) begin
            host.put(1'b0, row, {2'b00, code[8], 5'(c)}, code[7:0]);
            host.put(1'b1, row, {3'b000, 5'(c)}, c[0] ? ao : ae);
        end
        host.put(1'b0, row, 8'h1f, ~code[7:0]);
        host.put(1'b1, row, 8'h1e, ~ae);
        host.put(1'b1, row, 8'h1f, ~ae);
        host.idle();
    endtask
    task automatic look(input logic [4:0] row);
        @(posedge sys_clk);
        disp_row <= row;
        disp_on <= 1'b1;
        disp_line <= 6'(($random(seed) & 32'hff) % 18);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        {n_e, n_o, n_bg, n_box, n_rs, n_rt} = '0;
        mon = 1'b1;
        repeat (2000) @(negedge sys_clk);
        mon = 1'b0;
        @(posedge sys_clk);
        disp_on <= 1'b0;
    endtask
    task automatic frames(input int n);
        repeat (n) begin
            repeat (3) @(posedge sys_clk);
            frame_flyback_in <= 1'b1;
            repeat (4) @(posedge sys_clk);
            frame_flyback_in <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic report_and_stop();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #(100000 * 5);
        n_fail++;
        report_and_stop();
    end
    initial begin
        {seed, n_fail, n_compared, n_tick} = '0;
        seed = 9419;
        {rstn, line_flyback_in, frame_flyback_in, disp_on, mon, multi, fly_on} = '0;
        {osc_range_hi, osc_range_lo, fly_cnt, disp_row, disp_line} = '0;
        line_dots_div12 = 8'd40;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        fly_on <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 30 + (($random(seed) & 32'hff) % 12) : 62;
            line_dots_div12 <= 8'(v);
            repeat (4000) @(posedge sys_clk);
            while (fly_cnt != 10'd10) @(posedge sys_clk);
            @(negedge sys_clk);
            n_tick = 0;
            repeat (1000) @(posedge sys_clk);
            @(negedge sys_clk);
            `CHK("line_dots", 1'b1, n_tick >= v * 12 - 1 && n_tick <= v * 12 + 1)
            @(posedge sys_clk);
            for (int b = 0; b < 4; b++) begin
                {osc_range_hi, osc_range_lo} <= 2'(b);
                repeat (3) @(posedge sys_clk);
                `CHK("band_ok", band_exp(b, v), dot_band_ok)
            end
        end
        fly_on <= 1'b0;
        repeat (FLY + 300) @(posedge sys_clk);
        `CHK("locked", 1'b0, dot_locked)
        @(negedge sys_clk);
        n_tick = 0;
        repeat (10 * osdcar_pkg::OSC_DIV) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("osc_ticks", 10, n_tick)
        @(posedge sys_clk);
        fly_on <= 1'b1;
        repeat (4000) @(posedge sys_clk);
        fg_e = 3'($random(seed));
        fg_o = ~fg_e;
        bg_o = 3'($random(seed)) | 3'h1;
        exp_code = 9'(($random(seed) & 32'hffff) % 360);
        host.put(1'b0, 5'd2, 8'h1e, 8'h03);
        fill(5'd2, exp_code, {5'h00, fg_e}, {1'b0, bg_o, 1'b0, fg_o});
        fill(5'd3, 9'h167, {5'h00, fg_e}, {1'b0, bg_o, 1'b0, fg_o});
        look(5'd2);
        `CHK("odd_hidden", 0, n_o + n_bg)
        `CHK("even_shown", 1'b1, n_e > 0)
        disp_line <= 6'd21;
        repeat (2) @(posedge sys_clk);
        `CHK("tall_line", 5'd10, glyph_rom_line)
        exp_code = 9'h167;
        look(5'd3);
        `CHK("odd_shown", 1'b1, n_o > 0 && n_bg > 0)
        disp_line <= 6'd21;
        repeat (2) @(posedge sys_clk);
        `CHK("clamp_line", 5'd17, glyph_rom_line)
        exp_code = 9'h16a;
        fill(5'd5, exp_code, {5'h01, fg_e}, {5'h00, fg_o});
        look(5'd5);
        v = n_e;
        frames(31);
        look(5'd5);
        `CHK("blink_hold", v > 0, n_e > 0)
        `CHK("steady", 1'b1, n_o > 0)
        frames(1);
        look(5'd5);
        `CHK("blink_flip", v == 0, n_e > 0)
        multi = 1'b1;
        exp_code = osdcar_pkg::CODE_MULTI_FIRST;
        host.put(1'b0, 5'd6, 8'h1e, 8'h10);
        fill(5'd6, exp_code, 8'h24, 8'h24);
        for (int i = 0; i < 5; i++) begin
            s = (i == 0) ? 3'h0 : 3'(i + 3);
            host.put(1'b1, 5'd6, 8'h1d, 8'h14);
            host.put(1'b1, 5'd6, 8'h00, {1'b0, s, 4'h4});
            host.idle();
            look(5'd6);
            `CHK("box_seen", s != 3'h0, n_box > 0)
            `CHK("box_kind", s[1], n_rs == n_box && n_box > 0)
            `CHK("box_end", s != 3'h0, n_rt > 0)
            `CHK("multi_seen", 1'b1, n_e > 0)
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
